// ---- core/ghs_pkg.sv ----
// Shared constants for the host serial ports block
package ghs_pkg;
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned BAUD_MIN = 9600;
	localparam int unsigned BAUD_MAX = 921600;
	localparam int unsigned BAUD_RESET = 9600;
	localparam int DIV_W = 14;
	// Divisors round to nearest so the bit period error stays well inside one percent
	localparam logic [DIV_W-1:0] DIV_MIN = DIV_W'((CLK_HZ + BAUD_MAX / 2) / BAUD_MAX);
	localparam logic [DIV_W-1:0] DIV_MAX = DIV_W'((CLK_HZ + BAUD_MIN / 2) / BAUD_MIN);
	localparam logic [DIV_W-1:0] DIV_RESET = DIV_W'((CLK_HZ + BAUD_RESET / 2) / BAUD_RESET);
	localparam int DATA_BITS = 8;
	localparam logic [3:0] FRAME_BITS = 4'hA;
	localparam logic [6:0] I2C_ADDR_RESET = 7'h42;
	localparam int unsigned TSU_NS = 100;
	localparam int unsigned TSU_CYC = (TSU_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int unsigned STRETCH_MS = 20;
	localparam int unsigned STRETCH_CYC = STRETCH_MS * (CLK_HZ / 1000);
	localparam int unsigned GSV_S = 5;
	localparam int unsigned GSV_CYC = GSV_S * CLK_HZ;
	localparam int FIFO_DEPTH = 16;
	localparam logic [7:0] RD_FILL = 8'hFF;
endpackage

// ---- core/ghs_top.sv ----
// Host serial ports: UART with transmit FIFO and a two-wire target port
// What this block does
// - The UART takes any software-set divisor between the 9600 and 921600 baud points.
// - The UART has no RTS or CTS pins and neither side may pause it by hardware.
// - Transmit bits last a whole divisor of clocks so the rate stays within one percent.
// - The receiver resyncs on each start edge and samples mid-bit to tolerate 2.5 percent.
// - The two-wire port only follows Fast-mode bus timing.
// - The two-wire port is a target only and the controller keeps SCL at or below 320 kHz.
// - The port may hold SCL low to stall but releases it within 20 ms.
// - After reset the UART runs 9600 baud with 8 data bits, no parity and one stop bit.
// - After reset the two-wire port answers to 7-bit address 0x42.
// - The satellites-in-view sentence slot is offered once every five seconds.
// - After stretching, SDA is set at least one setup time before SCL is released.

module ghs_fifo #(
	parameter int W = 8,
	parameter int D = 16
) (
	input wire logic clk_i, // Clock
	input wire logic rst_i, // Async reset, high
	input wire logic [W-1:0] in_data_i, // Fill data
	input wire logic in_valid_i, // Fill request
	output logic in_ready_o, // Room available
	output logic [W-1:0] out_data_o, // Head word
	output logic out_valid_o, // Not empty
	input wire logic out_ready_i // Drain request
);
	localparam int AW = $clog2(D);
	if (D < 2 || (D & (D - 1)) != 0 || W < 1) begin : g_chk
		$error("ghs_fifo: depth must be a power of two of at least 2");
	end
	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW:0] cnt;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
	} ghs_fifo_st_t;
	ghs_fifo_st_t st_reg, st_next;
	logic push, pop;

	assign in_ready_o = st_reg.cnt != (AW + 1)'(D);
	assign out_valid_o = st_reg.cnt != '0;
	assign out_data_o = st_reg.mem[st_reg.rp];
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;

	always_comb begin
		st_next = st_reg;
		if (push) begin
			st_next.mem[st_reg.wp] = in_data_i;
			st_next.wp = st_reg.wp + 1'b1;
		end
		if (pop) begin
			st_next.rp = st_reg.rp + 1'b1;
		end
		st_next.cnt = st_reg.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end
endmodule

module ghs_top #(
	parameter int unsigned STRETCH_CYC = ghs_pkg::STRETCH_CYC,
	parameter int unsigned GSV_CYC = ghs_pkg::GSV_CYC,
	parameter int FIFO_DEPTH = ghs_pkg::FIFO_DEPTH
) (
	input wire logic MCLK_I, // 100 MHz clock
	input wire logic RESET_I, // Async reset, high
	input wire logic BAUD_SET_I, // Load new divisor
	input wire logic [ghs_pkg::DIV_W-1:0] BAUD_DIV_I, // Clocks per bit
	output logic [ghs_pkg::DIV_W-1:0] BAUD_DIV_O, // Divisor in use
	input wire logic [7:0] TX_DATA_I, // Byte to send
	input wire logic TX_VALID_I, // Byte offered
	output logic TX_READY_O, // FIFO has room
	output logic TXD_O, // UART line out
	input wire logic RXD_I, // UART line in
	output logic [7:0] RX_DATA_O, // Received byte
	output logic RX_VALID_O, // Received byte pulse
	output logic RX_FERR_O, // Framing error pulse
	input wire logic I2C_ADDR_SET_I, // Load new target address
	input wire logic [6:0] I2C_ADDR_I, // New target address
	input wire logic SCL_I, // SCL level
	output logic SCL_O, // SCL drive value
	output logic SCL_OE_O, // SCL pulled low
	input wire logic SDA_I, // SDA level
	output logic SDA_O, // SDA drive value
	output logic SDA_OE_O, // SDA pulled low
	output logic [7:0] I2C_WR_DATA_O, // Byte written by controller
	output logic I2C_WR_VALID_O, // Written byte pulse
	input wire logic [7:0] I2C_RD_DATA_I, // Byte for controller read
	input wire logic I2C_RD_VALID_I, // Read byte available
	output logic I2C_RD_READY_O, // Read byte taken
	output logic I2C_STRETCH_TO_O, // Stretch timed out pulse
	output logic GSV_SLOT_O // Sentence slot pulse
);
	if (STRETCH_CYC <= ghs_pkg::TSU_CYC || GSV_CYC < 2 || FIFO_DEPTH < 2) begin : g_chk
		$error("ghs_top: parameter out of range");
	end
	localparam int SW = $clog2(STRETCH_CYC + 1);
	localparam int GW = $clog2(GSV_CYC);
	localparam logic [SW-1:0] TSU_C = SW'(ghs_pkg::TSU_CYC);
	localparam logic [SW-1:0] STR_C = SW'(STRETCH_CYC);

	typedef enum logic [3:0] {
		U_IDLE = 4'h1, U_START = 4'h2, U_DATA = 4'h4, U_STOP = 4'h8
	} ghs_rx_t;
	typedef enum logic [1:0] {T_IDLE = 2'h1, T_SHIFT = 2'h2} ghs_tx_t;
	typedef enum logic [7:0] {
		I_IDLE = 8'h01, I_ADDR = 8'h02, I_AACK = 8'h04, I_WDATA = 8'h08,
		I_WACK = 8'h10, I_RWAIT = 8'h20, I_RDATA = 8'h40, I_RACK = 8'h80
	} ghs_i2c_t;

	typedef struct packed {
		logic [ghs_pkg::DIV_W-1:0] div;
		ghs_tx_t tx;
		logic [ghs_pkg::DIV_W-1:0] tcnt;
		logic [3:0] tbits;
		logic [9:0] tsh;
		ghs_rx_t rx;
		logic [ghs_pkg::DIV_W-1:0] rcnt;
		logic [2:0] rbits;
		logic [7:0] rsh;
		logic [7:0] rx_data;
		logic rx_valid;
		logic rx_ferr;
		ghs_i2c_t i2c;
		logic [6:0] addr;
		logic scl_prev;
		logic sda_prev;
		logic [3:0] ibits;
		logic [7:0] ish;
		logic rw;
		logic acked;
		logic loaded;
		logic [SW-1:0] tmr;
		logic scl_oe;
		logic sda_oe;
		logic [7:0] wr_data;
		logic wr_valid;
		logic str_to;
		logic [GW-1:0] gcnt;
		logic gsv;
	} ghs_st_t;
	ghs_st_t st_reg, st_next;

	logic [7:0] f_data;
	logic f_valid, f_ready;
	logic scl_rise, scl_fall, i2c_start, i2c_stop;

	// No flow control pins: the FIFO ready is the only stall, and it faces the user side
	ghs_fifo #(.W(8), .D(FIFO_DEPTH)) u_txq (
		.clk_i(MCLK_I),
		.rst_i(RESET_I),
		.in_data_i(TX_DATA_I),
		.in_valid_i(TX_VALID_I),
		.in_ready_o(TX_READY_O),
		.out_data_o(f_data),
		.out_valid_o(f_valid),
		.out_ready_i(f_ready)
	);

	assign f_ready = st_reg.tx == T_IDLE;
	assign scl_rise = SCL_I && !st_reg.scl_prev;
	assign scl_fall = !SCL_I && st_reg.scl_prev;
	// Edges sampled at 100 MHz resolve Fast-mode timing; no controller logic exists
	assign i2c_start = SCL_I && st_reg.scl_prev && st_reg.sda_prev && !SDA_I;
	assign i2c_stop = SCL_I && st_reg.scl_prev && !st_reg.sda_prev && SDA_I;
	assign I2C_RD_READY_O = st_reg.i2c == I_RWAIT && !st_reg.loaded && I2C_RD_VALID_I;

	always_comb begin
		st_next = st_reg;
		st_next.rx_valid = 1'b0;
		st_next.rx_ferr = 1'b0;
		st_next.wr_valid = 1'b0;
		st_next.str_to = 1'b0;
		st_next.gsv = 1'b0;
		st_next.scl_prev = SCL_I;
		st_next.sda_prev = SDA_I;

		if (BAUD_SET_I && BAUD_DIV_I >= ghs_pkg::DIV_MIN && BAUD_DIV_I <= ghs_pkg::DIV_MAX) begin
			st_next.div = BAUD_DIV_I;
		end
		if (I2C_ADDR_SET_I) begin
			st_next.addr = I2C_ADDR_I;
		end

		// Transmit: start, 8 data LSB first, stop; no parity
		case (st_reg.tx)
			T_IDLE: begin
				if (f_valid) begin
					st_next.tsh = {1'b1, f_data, 1'b0};
					st_next.tbits = '0;
					st_next.tcnt = st_reg.div - 1'b1;
					st_next.tx = T_SHIFT;
				end
			end
			T_SHIFT: begin
				if (st_reg.tcnt == '0) begin
					st_next.tcnt = st_reg.div - 1'b1;
					st_next.tsh = {1'b1, st_reg.tsh[9:1]};
					st_next.tbits = st_reg.tbits + 1'b1;
					if (st_reg.tbits == ghs_pkg::FRAME_BITS - 1'b1) begin
						st_next.tx = T_IDLE;
					end
				end else begin
					st_next.tcnt = st_reg.tcnt - 1'b1;
				end
			end
			default: st_next.tx = T_IDLE;
		endcase

		// Receive: half-bit to the start centre, then whole bits
		case (st_reg.rx)
			U_IDLE: begin
				if (!RXD_I) begin
					st_next.rcnt = st_reg.div >> 1;
					st_next.rx = U_START;
				end
			end
			U_START: begin
				if (st_reg.rcnt == '0) begin
					st_next.rcnt = st_reg.div - 1'b1;
					st_next.rbits = '0;
					st_next.rx = RXD_I ? U_IDLE : U_DATA;
				end else begin
					st_next.rcnt = st_reg.rcnt - 1'b1;
				end
			end
			U_DATA: begin
				if (st_reg.rcnt == '0) begin
					st_next.rcnt = st_reg.div - 1'b1;
					st_next.rsh = {RXD_I, st_reg.rsh[7:1]};
					st_next.rbits = st_reg.rbits + 1'b1;
					if (st_reg.rbits == 3'(ghs_pkg::DATA_BITS - 1)) begin
						st_next.rx = U_STOP;
					end
				end else begin
					st_next.rcnt = st_reg.rcnt - 1'b1;
				end
			end
			U_STOP: begin
				if (st_reg.rcnt == '0) begin
					st_next.rx = U_IDLE;
					if (RXD_I) begin
						st_next.rx_data = st_reg.rsh;
						st_next.rx_valid = 1'b1;
					end else begin
						st_next.rx_ferr = 1'b1;
					end
				end else begin
					st_next.rcnt = st_reg.rcnt - 1'b1;
				end
			end
			default: st_next.rx = U_IDLE;
		endcase

		// Two-wire target; SDA only changes while SCL is low
		case (st_reg.i2c)
			I_IDLE: begin
				st_next.sda_oe = 1'b0;
				st_next.scl_oe = 1'b0;
			end
			I_ADDR, I_WDATA: begin
				if (scl_rise) begin
					st_next.ish = {st_reg.ish[6:0], SDA_I};
					st_next.ibits = st_reg.ibits + 1'b1;
				end else if (scl_fall && st_reg.ibits == 4'h8) begin
					if (st_reg.i2c == I_WDATA) begin
						st_next.wr_data = st_reg.ish;
						st_next.wr_valid = 1'b1;
						st_next.sda_oe = 1'b1;
						st_next.i2c = I_WACK;
					end else if (st_reg.ish[7:1] == st_reg.addr) begin
						st_next.rw = st_reg.ish[0];
						st_next.sda_oe = 1'b1;
						st_next.i2c = I_AACK;
					end else begin
						st_next.i2c = I_IDLE;
					end
				end
			end
			I_WACK: begin
				if (scl_fall) begin
					st_next.sda_oe = 1'b0;
					st_next.ibits = '0;
					st_next.i2c = I_WDATA;
				end
			end
			I_AACK, I_RACK: begin
				if (scl_rise) begin
					st_next.acked = !SDA_I;
				end
				if (scl_fall) begin
					st_next.sda_oe = 1'b0;
					st_next.ibits = '0;
					if (st_reg.i2c == I_AACK ? st_reg.rw : st_reg.acked) begin
						st_next.scl_oe = 1'b1;
						st_next.loaded = 1'b0;
						st_next.tmr = '0;
						st_next.i2c = I_RWAIT;
					end else begin
						st_next.i2c = st_reg.i2c == I_AACK ? I_WDATA : I_IDLE;
					end
				end
			end
			I_RWAIT: begin
				st_next.tmr = st_reg.tmr + 1'b1;
				if (!st_reg.loaded) begin
					// Fill early enough that the whole hold, setup included, stays in bound
					if (I2C_RD_VALID_I || st_reg.tmr == STR_C - TSU_C - 1'b1) begin
						st_next.ish = I2C_RD_VALID_I ? I2C_RD_DATA_I : ghs_pkg::RD_FILL;
						st_next.sda_oe = I2C_RD_VALID_I ? !I2C_RD_DATA_I[7] : 1'b0;
						st_next.str_to = !I2C_RD_VALID_I;
						st_next.loaded = 1'b1;
						st_next.tmr = '0;
					end
				end else if (st_reg.tmr == TSU_C - 1'b1) begin
					st_next.scl_oe = 1'b0;
					st_next.i2c = I_RDATA;
				end
			end
			I_RDATA: begin
				if (scl_rise) begin
					st_next.ibits = st_reg.ibits + 1'b1;
				end else if (scl_fall) begin
					if (st_reg.ibits == 4'h8) begin
						st_next.sda_oe = 1'b0;
						st_next.i2c = I_RACK;
					end else begin
						st_next.ish = {st_reg.ish[6:0], 1'b0};
						st_next.sda_oe = !st_reg.ish[6];
					end
				end
			end
			default: st_next.i2c = I_IDLE;
		endcase
		if (i2c_start) begin
			st_next.ibits = '0;
			st_next.sda_oe = 1'b0;
			st_next.i2c = I_ADDR;
		end else if (i2c_stop) begin
			st_next.sda_oe = 1'b0;
			st_next.i2c = I_IDLE;
		end

		// Sentence slot pulse every GSV_CYC clocks; it does not gate the transmit FIFO
		if (st_reg.gcnt == GW'(GSV_CYC - 1)) begin
			st_next.gcnt = '0;
			st_next.gsv = 1'b1;
		end else begin
			st_next.gcnt = st_reg.gcnt + 1'b1;
		end
	end

	always_ff @(posedge MCLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			st_reg <= '0;
			st_reg.div <= ghs_pkg::DIV_RESET;
			st_reg.addr <= ghs_pkg::I2C_ADDR_RESET;
			st_reg.tx <= T_IDLE;
			st_reg.tsh <= 10'h3FF;
			st_reg.rx <= U_IDLE;
			st_reg.i2c <= I_IDLE;
			st_reg.scl_prev <= 1'b1;
			st_reg.sda_prev <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	assign BAUD_DIV_O = st_reg.div;
	assign TXD_O = st_reg.tx == T_IDLE ? 1'b1 : st_reg.tsh[0];
	assign RX_DATA_O = st_reg.rx_data;
	assign RX_VALID_O = st_reg.rx_valid;
	assign RX_FERR_O = st_reg.rx_ferr;
	assign SCL_O = 1'b0;
	assign SCL_OE_O = st_reg.scl_oe;
	assign SDA_O = 1'b0;
	assign SDA_OE_O = st_reg.sda_oe;
	assign I2C_WR_DATA_O = st_reg.wr_data;
	assign I2C_WR_VALID_O = st_reg.wr_valid;
	assign I2C_STRETCH_TO_O = st_reg.str_to;
	assign GSV_SLOT_O = st_reg.gsv;
endmodule

// ---- tb/ghs_checker.sv ----
// Assertions on the host serial ports top
module ghs_checker #(
	parameter int unsigned STRETCH_CYC = 200,
	parameter int unsigned GSV_CYC = 50
) (
	input wire logic MCLK_I, // Clock
	input wire logic RESET_I, // Reset
	input wire logic [ghs_pkg::DIV_W-1:0] BAUD_DIV_O, // Divisor
	input wire logic TXD_O, // Tx line
	input wire logic RX_VALID_O, // Rx byte
	input wire logic RX_FERR_O, // Rx error
	input wire logic SCL_I, // SCL level
	input wire logic SCL_OE_O, // SCL hold
	input wire logic SDA_OE_O, // SDA pull
	input wire logic I2C_STRETCH_TO_O, // Timeout
	input wire logic GSV_SLOT_O // Slot
);
	timeunit 1ns;
	timeprecision 1ns;
	logic txd_reg;
	logic sda_reg;
	logic seen_reg;
	int run_reg;
	int age_reg;
	int hold_reg;
	int gap_reg;
	always_ff @(posedge MCLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			txd_reg <= 1'b1;
			sda_reg <= 1'b0;
			seen_reg <= 1'b0;
			run_reg <= 0;
			age_reg <= 0;
			hold_reg <= 0;
			gap_reg <= 0;
		end else begin
			txd_reg <= TXD_O;
			sda_reg <= SDA_OE_O;
			seen_reg <= seen_reg | GSV_SLOT_O;
			run_reg <= (TXD_O != txd_reg) ? 1 : run_reg + 1;
			age_reg <= (SDA_OE_O != sda_reg) ? 1 : age_reg + 1;
			hold_reg <= SCL_OE_O ? hold_reg + 1 : 0;
			gap_reg <= GSV_SLOT_O ? 1 : gap_reg + 1;
		end
	end
	default clocking @(posedge MCLK_I);
	endclocking
	default disable iff (RESET_I);
	a_div_range: assert property (BAUD_DIV_O inside {[ghs_pkg::DIV_MIN:ghs_pkg::DIV_MAX]})
		else $error("divisor out of range");
	a_div_reset: assert property ($past(RESET_I) |-> BAUD_DIV_O == ghs_pkg::DIV_RESET)
		else $error("reset divisor wrong");
	a_tx_bit_time: assert property (TXD_O && !txd_reg |-> run_reg % BAUD_DIV_O == 0)
		else $error("low run not whole bits");
	a_rx_one_flag: assert property (!(RX_VALID_O && RX_FERR_O))
		else $error("byte both good and bad");
	a_stretch_max: assert property (hold_reg <= STRETCH_CYC)
		else $error("stretch too long");
	a_sda_setup: assert property ($fell(SCL_OE_O) |-> age_reg >= ghs_pkg::TSU_CYC)
		else $error("data setup too short");
	a_scl_target: assert property ($rose(SCL_OE_O) |-> !$past(SCL_I))
		else $error("target drove a clock");
	a_gsv_period: assert property (GSV_SLOT_O && seen_reg |-> gap_reg == GSV_CYC)
		else $error("slot period wrong");
	c_ferr: cover property (RX_FERR_O);
	c_timeout: cover property (I2C_STRETCH_TO_O);
	c_release: cover property ($fell(SCL_OE_O));
endmodule

// ---- tb/ghs_host_ctl.sv ----
// Host-side two-wire bus controller model
module ghs_host_ctl (
	input wire logic clk_i, // Clock
	input wire logic scl_i, // SCL level
	input wire logic sda_i, // SDA level
	output logic scl_low_o, // Pulls SCL low
	output logic sda_low_o // Pulls SDA low
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int HALF = 160; // 320 cycle bit, about 312 kHz
	initial begin
		scl_low_o = 1'b0;
		sda_low_o = 1'b0;
	end
	task automatic wait_n(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic bit_x(input logic b, output logic r);
		int n;
		wait_n(40);
		sda_low_o <= !b;
		wait_n(HALF - 40);
		scl_low_o <= 1'b0;
		// Hold off while the target stretches the clock
		for (n = 0; n < 400 && !scl_i; n++) @(posedge clk_i);
		wait_n(HALF);
		r = sda_i;
		scl_low_o <= 1'b1;
	endtask
	task automatic xfer(input logic [7:0] w, input logic ai, output logic [7:0] rd,
		output logic ack);
		for (int i = 7; i >= 0; i--) bit_x(w[i], rd[i]);
		bit_x(ai, ack);
		ack = !ack;
	endtask
	task automatic start();
		sda_low_o <= 1'b0;
		scl_low_o <= 1'b0;
		wait_n(HALF);
		sda_low_o <= 1'b1;
		wait_n(HALF);
		scl_low_o <= 1'b1;
	endtask
	task automatic stop();
		wait_n(40);
		sda_low_o <= 1'b1;
		wait_n(HALF);
		scl_low_o <= 1'b0;
		wait_n(HALF);
		sda_low_o <= 1'b0;
		wait_n(HALF);
	endtask
endmodule

// ---- tb/ghs_top_tb_top.sv ----
// Testbench for the host serial ports block
module ghs_top_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk;
	logic rst = 1'b1;
	logic bset = 1'b0;
	logic [ghs_pkg::DIV_W-1:0] bdiv = '0;
	logic [7:0] txd_i = '0;
	logic txv = 1'b0;
	logic rxd = 1'b1;
	logic loop = 1'b1;
	logic [7:0] rdd = '0;
	logic rdv = 1'b0;
	logic aset = 1'b0;
	logic [6:0] aval = '0;
	logic [7:0] wr_last = '0;
	logic [7:0] ferr = '0;
	logic [7:0] to_n = '0;
	logic [7:0] rxq[$];
	int mismatches = 0;
	int checks_done = 0;
	int cyc = 0;
	wire [ghs_pkg::DIV_W-1:0] div_o;
	wire [7:0] rx_d, wr_d;
	wire txd, trdy, rxv, rxf, scl_oe, sda_oe, wrv, rdr, sto, gsv, scl_low, sda_low;
	wire scl = !(scl_oe || scl_low);
	wire sda = !(sda_oe || sda_low);
	ghs_top #(.STRETCH_CYC(200), .GSV_CYC(50), .FIFO_DEPTH(16)) dut_u (
		.MCLK_I(clk), .RESET_I(rst), .BAUD_SET_I(bset), .BAUD_DIV_I(bdiv), .BAUD_DIV_O(div_o),
		.TX_DATA_I(txd_i), .TX_VALID_I(txv), .TX_READY_O(trdy), .TXD_O(txd),
		.RXD_I(loop ? txd : rxd), .RX_DATA_O(rx_d), .RX_VALID_O(rxv), .RX_FERR_O(rxf),
		.I2C_ADDR_SET_I(aset), .I2C_ADDR_I(aval), .SCL_I(scl), .SCL_O(), .SCL_OE_O(scl_oe),
		.SDA_I(sda), .SDA_O(), .SDA_OE_O(sda_oe), .I2C_WR_DATA_O(wr_d), .I2C_WR_VALID_O(wrv),
		.I2C_RD_DATA_I(rdd), .I2C_RD_VALID_I(rdv), .I2C_RD_READY_O(rdr),
		.I2C_STRETCH_TO_O(sto), .GSV_SLOT_O(gsv));
	ghs_host_ctl host_u (.clk_i(clk), .scl_i(scl), .sda_i(sda), .scl_low_o(scl_low),
		.sda_low_o(sda_low));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	always @(posedge clk) begin
		cyc++;
		if (rxv) rxq.push_back(rx_d);
		if (rxf) ferr <= ferr + 8'h01;
		if (sto) to_n <= to_n + 8'h01;
		if (wrv) wr_last <= wr_d;
		if (rdr) rdv <= 1'b0;
		if (cyc == 95000) begin
			mismatches++;
			end_sim();
		end
	end
	task automatic set_div(input logic [ghs_pkg::DIV_W-1:0] d, e);
		bdiv <= d;
		bset <= 1'b1;
		@(posedge clk);
		bset <= 1'b0;
		// Let the loaded divisor settle before it is judged
		@(posedge clk);
		for (int i = 0; i < 10500 && div_o !== e; i++) @(posedge clk);
		chk(16'(div_o), 16'(e));
	endtask
	task automatic uart_drv(input logic [7:0] b, input int per, input logic stp);
		logic [10:0] f;
		f = {1'b1, stp, b, 1'b0};
		for (int i = 0; i < 11; i++) begin
			rxd <= f[i];
			repeat (per) @(posedge clk);
		end
	endtask
	task automatic t_base();
		int g;
		chk({12'h000, trdy, txd, scl_oe, sda_oe}, 16'h000C);
		chk(16'(div_o), 16'(ghs_pkg::DIV_RESET));
		set_div(14'd108, ghs_pkg::DIV_RESET);
		set_div(ghs_pkg::DIV_MIN, ghs_pkg::DIV_MIN);
		g = 0;
		while (!gsv) @(posedge clk);
		do begin
			@(posedge clk);
			g++;
		end while (!gsv);
		chk(16'(g), 16'h0032);
		$display("test base done");
	endtask
	task automatic t_txrx();
		int n;
		n = 0;
		txd_i <= 8'h30;
		txv <= 1'b1;
		while (n < 40) begin
			@(posedge clk);
			if (!trdy) break;
			n++;
			txd_i <= 8'h30 + 8'(n);
		end
		txv <= 1'b0;
		chk(16'(n >= 16 && n <= 17), 16'h0001);
		for (int i = 0; i < 20000 && rxq.size() < n; i++) @(posedge clk);
		chk(16'(rxq.size()), 16'(n));
		for (int k = 0; k < rxq.size(); k++) chk(16'(rxq[k]), 16'(8'h30 + 8'(k)));
		chk(16'(trdy), 16'h0001);
		$display("test tx and rx done");
	endtask
	task automatic t_rx();
		int s;
		set_div(14'd400, 14'd400);
		loop <= 1'b0;
		s = rxq.size();
		uart_drv(8'hA5, 410, 1'b1);
		uart_drv(8'h5A, 390, 1'b1);
		uart_drv(8'h3C, 400, 1'b0);
		repeat (800) @(posedge clk);
		chk(16'(rxq.size() - s), 16'h0002);
		chk({rxq[s], rxq[s+1]}, 16'hA55A);
		chk(16'(ferr), 16'h0001);
		$display("test rx tolerance done");
	endtask
	task automatic t_i2c();
		logic [7:0] r;
		logic a;
		host_u.start();
		host_u.xfer({7'h42, 1'b0}, 1'b1, r, a);
		chk(16'(a), 16'h0001);
		host_u.xfer(8'hC3, 1'b1, r, a);
		host_u.stop();
		chk({7'h00, a, wr_last}, 16'h01C3);
		host_u.start();
		host_u.xfer({7'h43, 1'b0}, 1'b1, r, a);
		chk(16'(a), 16'h0000);
		host_u.stop();
		rdd <= 8'h96;
		rdv <= 1'b1;
		host_u.start();
		host_u.xfer({7'h42, 1'b1}, 1'b1, r, a);
		host_u.xfer(8'hFF, 1'b0, r, a);
		chk(16'(r), 16'h0096);
		host_u.xfer(8'hFF, 1'b1, r, a);
		host_u.stop();
		chk({to_n, r}, 16'h01FF);
		aval <= 7'h21;
		aset <= 1'b1;
		@(posedge clk);
		aset <= 1'b0;
		host_u.start();
		host_u.xfer({7'h21, 1'b0}, 1'b1, r, a);
		host_u.stop();
		chk(16'(a), 16'h0001);
		$display("test two-wire done");
	endtask
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_base();
		t_txrx();
		t_rx();
		t_i2c();
		end_sim();
	end
endmodule
bind ghs_top ghs_checker #(.STRETCH_CYC(STRETCH_CYC), .GSV_CYC(GSV_CYC)) chk_u (
	.MCLK_I(MCLK_I), .RESET_I(RESET_I), .BAUD_DIV_O(BAUD_DIV_O), .TXD_O(TXD_O),
	.RX_VALID_O(RX_VALID_O), .RX_FERR_O(RX_FERR_O), .SCL_I(SCL_I), .SCL_OE_O(SCL_OE_O),
	.SDA_OE_O(SDA_OE_O), .I2C_STRETCH_TO_O(I2C_STRETCH_TO_O), .GSV_SLOT_O(GSV_SLOT_O));
